// File: hdl/simd_dup_truncate_datapath.sv
`timescale 1ns/1ps
module simd_dup_truncate_datapath
  import simd_dup_pkg::*;
(
  input  wire logic              CLK,         // Core clock, 10 MHz
  input  wire logic              RST_N,       // Asynchronous reset
  input  wire logic              FEATURE_EN,  // Extension implemented
  input  wire logic              LONG_MODE,   // 64-bit mode active
  input  wire logic              ISSUE_VALID, // Decoded op offered
  input  wire op_t               ISSUE_OP,    // Decoded operation
  input  wire logic [2:0]        DEST_IDX,    // Base vector index
  input  wire logic              PFX_PRESENT, // Extension prefix seen
  input  wire logic              PFX_R,       // Prefix register bit
  input  wire logic              PFX_W,       // Operand width bit
  input  wire logic [VEC_W-1:0]  VEC_SRC,     // Vector source
  input  wire logic [FPX_W-1:0]  FP_TOP,      // Stack top value
  input  wire logic [15:0]       FP_CW,       // Stack control word
  input  wire logic [ADDR_W-1:0] GPR_ADDR,    // Watch address reg
  input  wire logic [31:0]       GPR_HINT,    // Wait hint reg
  input  wire logic [ADDR_W-1:0] LOAD_ADDR,   // Load byte address
  input  wire logic              MEM_VALID,   // Memory data ready
  input  wire logic [BLK_W-1:0]  MEM_DATA,    // Memory block
  output logic                   ISSUE_READY, // Op can be taken
  output logic [ID_W-1:0]        ID_FLAGS,    // Query result word
  output logic                   UD_FAULT,    // Invalid opcode
  output logic                   VEC_WE,      // Vector write
  output logic [3:0]             VEC_IDX,     // Vector write index
  output logic [VEC_W-1:0]       VEC_DATA,    // Vector write data
  output logic                   INT_WE,      // Integer store
  output logic [QW_W-1:0]        INT_DATA,    // Integer store data
  output logic [1:0]             INT_WIDTH,   // Integer store width
  output logic                   FP_POP,      // Pop stack once
  output logic                   FP_INVALID,  // Invalid operand
  output logic                   FP_INEXACT,  // Inexact result
  output logic                   FP_FAULT,    // Unmasked exception
  output logic                   MEM_REQ,     // Memory read request
  output logic [ADDR_W-1:0]      MEM_ADDR,    // Aligned address
  output logic                   MEM_WIDE,    // 32-byte fetch
  output logic                   WATCH_VALID, // Watch armed
  output logic [ADDR_W-1:0]      WATCH_ADDR,  // Watched address
  output logic                   WAIT_VALID,  // Wait requested
  output logic [31:0]            WAIT_HINT    // Wait hint
);

  state_t               state_r;
  state_t               state_nxt;
  logic [3:0]           off_r;
  logic [3:0]           ld_idx_r;
  logic                 accept;
  logic                 go;
  logic                 ext_bit;
  logic                 trunc_op;
  logic [1:0]           trunc_w;
  conv_if               cv ();

  // ****************************************************************
  // Lane helpers
  // ****************************************************************
  // Lane k sits at bits 32k+31:32k, element zero in the low half.
  function automatic logic [LANE_W-1:0] lane(input logic [VEC_W-1:0] v,
                                             input int k);
    lane = v[k*LANE_W +: LANE_W];
  endfunction

  function automatic logic [VEC_W-1:0] dup_pair(
      input logic [VEC_W-1:0] v, input int base);
    dup_pair = {lane(v, base + 2), lane(v, base + 2),
                lane(v, base), lane(v, base)};
  endfunction

  function automatic logic [VEC_W-1:0] pick16(
      input logic [BLK_W-1:0] blk, input logic [3:0] off);
    logic [BLK_W-1:0] t;
    t = blk >> {off, 3'b000};
    pick16 = t[VEC_W-1:0];
  endfunction

  // ****************************************************************
  // Issue decode
  // ****************************************************************
  // Compatibility mode drives LONG_MODE low and so takes the same path
  // as protected mode; the prefix only counts in long mode.
  assign accept   = ISSUE_VALID && ISSUE_READY;
  assign go       = accept && FEATURE_EN;
  assign ext_bit  = LONG_MODE && PFX_PRESENT && PFX_R;
  assign trunc_op = (ISSUE_OP == OP_TRUNC16) || (ISSUE_OP == OP_TRUNC32) ||
                    (ISSUE_OP == OP_TRUNC64);
  assign trunc_w  = (ISSUE_OP == OP_TRUNC16) ? IW_16 :
                    (ISSUE_OP == OP_TRUNC32) ? IW_32 : IW_64;

  assign cv.value = FP_TOP;
  assign cv.width = trunc_w;

  fp_trunc_conv u_conv (
    .c (cv)
  );

  // ****************************************************************
  // Control state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (go && ISSUE_OP == OP_LOAD) begin
        state_nxt = ST_MEM;
      end
      ST_MEM: if (MEM_VALID) begin
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r     <= ST_IDLE;
      ISSUE_READY <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ISSUE_READY <= (state_nxt == ST_IDLE);
    end
  end

  // The query word is recomputed each cycle from the implementation
  // strap; it is a report, not a new piece of programmer state.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ID_FLAGS <= '0;
    end else begin
      ID_FLAGS <= '0;
      ID_FLAGS[ID_PRESENT_BIT] <= FEATURE_EN;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      UD_FAULT <= 1'b0;
    end else begin
      UD_FAULT <= accept && !FEATURE_EN && ISSUE_OP != OP_NONE;
    end
  end

  // ****************************************************************
  // Vector results: duplicate moves and the split-avoiding load
  // ****************************************************************
  // The duplicate moves only copy bits, so the vector control register
  // has nothing to round or flag here and is not an input.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      VEC_WE   <= 1'b0;
      VEC_IDX  <= '0;
      VEC_DATA <= '0;
    end else begin
      VEC_WE <= 1'b0;
      if (go) begin
        case (ISSUE_OP)
          OP_ODD_DUP: begin
            VEC_WE   <= 1'b1;
            VEC_IDX  <= {ext_bit, DEST_IDX};
            VEC_DATA <= dup_pair(VEC_SRC, 1);
          end
          OP_EVEN_DUP: begin
            VEC_WE   <= 1'b1;
            VEC_IDX  <= {ext_bit, DEST_IDX};
            VEC_DATA <= dup_pair(VEC_SRC, 0);
          end
          OP_QUAD_DUP: begin
            VEC_WE   <= 1'b1;
            VEC_IDX  <= {ext_bit, DEST_IDX};
            VEC_DATA <= {2{VEC_SRC[QW_W-1:0]}};
          end
          default: VEC_WE <= 1'b0;
        endcase
      end else if (state_r == ST_MEM && MEM_VALID) begin
        VEC_WE   <= 1'b1;
        VEC_IDX  <= ld_idx_r;
        VEC_DATA <= pick16(MEM_DATA, off_r);
      end
    end
  end

  // An aligned request asks for 16 bytes only; a misaligned one asks
  // for the two aligned lines around it, so no fetch ever straddles.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_REQ  <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WIDE <= 1'b0;
      off_r    <= '0;
      ld_idx_r <= '0;
    end else begin
      MEM_REQ <= 1'b0;
      if (go && ISSUE_OP == OP_LOAD) begin
        MEM_REQ  <= 1'b1;
        MEM_ADDR <= {LOAD_ADDR[ADDR_W-1:ALIGN_BITS], 4'h0};
        MEM_WIDE <= (LOAD_ADDR[ALIGN_BITS-1:0] != 4'h0);
        off_r    <= LOAD_ADDR[ALIGN_BITS-1:0];
        ld_idx_r <= {ext_bit, DEST_IDX};
      end
    end
  end

  // ****************************************************************
  // Truncating integer store
  // ****************************************************************
  // Only the invalid and precision masks of the control word are read.
  // An unmasked invalid operand stores nothing and keeps the stack.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      INT_WE     <= 1'b0;
      INT_DATA   <= '0;
      INT_WIDTH  <= IW_16;
      FP_POP     <= 1'b0;
      FP_INVALID <= 1'b0;
      FP_INEXACT <= 1'b0;
      FP_FAULT   <= 1'b0;
    end else begin
      INT_WE     <= 1'b0;
      FP_POP     <= 1'b0;
      FP_INVALID <= 1'b0;
      FP_INEXACT <= 1'b0;
      FP_FAULT   <= 1'b0;
      if (go && trunc_op) begin
        FP_INVALID <= cv.invalid;
        FP_INEXACT <= cv.inexact;
        FP_FAULT   <= (cv.invalid && !FP_CW[CW_IM_BIT]) ||
                      (cv.inexact && !FP_CW[CW_PM_BIT]);
        if (!(cv.invalid && !FP_CW[CW_IM_BIT])) begin
          INT_WE    <= 1'b1;
          INT_DATA  <= cv.result;
          INT_WIDTH <= trunc_w;
          FP_POP    <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Address watch and wait
  // ****************************************************************
  // Register operands are only read; no path writes a general register.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WATCH_VALID <= 1'b0;
      WATCH_ADDR  <= '0;
      WAIT_VALID  <= 1'b0;
      WAIT_HINT   <= '0;
    end else begin
      WATCH_VALID <= go && ISSUE_OP == OP_WATCH;
      WAIT_VALID  <= go && ISSUE_OP == OP_WAIT;
      if (go && ISSUE_OP == OP_WATCH) begin
        if (LONG_MODE && PFX_PRESENT && PFX_W) begin
          WATCH_ADDR <= GPR_ADDR;
        end else begin
          WATCH_ADDR <= {32'h0000_0000, GPR_ADDR[NARROW_W-1:0]};
        end
      end
      if (go && ISSUE_OP == OP_WAIT) begin
        WAIT_HINT <= GPR_HINT;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_absent_faults: assert property (
    accept && !FEATURE_EN && ISSUE_OP == OP_ODD_DUP
    |=> UD_FAULT && !VEC_WE && !INT_WE && !MEM_REQ)
    else $error("absent extension did not fault");

  // The edge that releases reset still samples RST_N low, so the first
  // attempt starts one edge later, when the flag has a value to report.
  a_presence_bit: assert property (
    RST_N |=> ID_FLAGS[ID_PRESENT_BIT] == $past(FEATURE_EN))
    else $error("presence bit wrong");

  a_odd_dup_data: assert property (
    go && ISSUE_OP == OP_ODD_DUP |=> VEC_WE &&
    VEC_DATA[31:0] == $past(VEC_SRC[63:32]) &&
    VEC_DATA[127:96] == $past(VEC_SRC[127:96]))
    else $error("odd duplicate data wrong");

  a_even_dup_data: assert property (
    go && ISSUE_OP == OP_EVEN_DUP |=> VEC_WE &&
    VEC_DATA[63:32] == $past(VEC_SRC[31:0]) &&
    VEC_DATA[95:64] == $past(VEC_SRC[95:64]))
    else $error("even duplicate data wrong");

  a_quad_dup_data: assert property (
    go && ISSUE_OP == OP_QUAD_DUP |=> VEC_WE &&
    VEC_DATA[127:64] == $past(VEC_SRC[63:0]))
    else $error("quadword duplicate data wrong");

  a_store_pops: assert property (
    go && trunc_op |=> (INT_WE == FP_POP) && (INT_WE || FP_FAULT))
    else $error("store and pop disagree");

  a_load_align: assert property (
    go && ISSUE_OP == OP_LOAD |=> MEM_REQ && MEM_ADDR[3:0] == 4'h0 &&
    MEM_WIDE == ($past(LOAD_ADDR[3:0]) != 4'h0) ##1 !MEM_REQ)
    else $error("load request shape wrong");

  a_load_extract: assert property (
    state_r == ST_MEM && MEM_VALID |=> VEC_WE && VEC_IDX == ld_idx_r &&
    VEC_DATA == pick16($past(MEM_DATA), off_r) && ISSUE_READY)
    else $error("load extraction wrong");

  a_reg_extend: assert property (
    go && ISSUE_OP == OP_EVEN_DUP
    |=> VEC_IDX[3] == $past(LONG_MODE && PFX_PRESENT && PFX_R))
    else $error("extended register index wrong");

  a_watch_width: assert property (
    go && ISSUE_OP == OP_WATCH && !LONG_MODE
    |=> WATCH_VALID && WATCH_ADDR[63:32] == 32'h0000_0000)
    else $error("watch address width wrong");

  c_odd_dup:   cover property (go && ISSUE_OP == OP_ODD_DUP);
  c_misalign:  cover property (MEM_REQ && MEM_WIDE ##[1:8] VEC_WE);
  c_inexact:   cover property (INT_WE && FP_INEXACT);
  c_absent:    cover property (UD_FAULT);

endmodule

// File: hdl/simd_dup_pkg.sv
package simd_dup_pkg;

  // ****************************************************************
  // Widths and field positions
  // ****************************************************************
  localparam int LANE_W      = 32;
  localparam int QW_W        = 64;
  localparam int VEC_W       = 128;
  localparam int BLK_W       = 256;
  localparam int FPX_W       = 80;
  localparam int ADDR_W      = 64;
  localparam int ID_W        = 32;
  localparam int ID_PRESENT_BIT = 0;
  localparam int CW_IM_BIT   = 0;
  localparam int CW_PM_BIT   = 5;
  localparam int ALIGN_BITS  = 4;
  localparam int NARROW_W    = 32;

  // ****************************************************************
  // Extended precision format and integer widths
  // ****************************************************************
  localparam logic [14:0] EXP_SPECIAL = 15'h7FFF;
  localparam logic [15:0] EXP_BIAS    = 16'h3FFF;
  localparam logic [1:0]  IW_16       = 2'h0;
  localparam logic [1:0]  IW_32       = 2'h1;
  localparam logic [1:0]  IW_64       = 2'h2;

  // ****************************************************************
  // Operations and states
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_TRUNC16  = 4'h0,
    OP_TRUNC32  = 4'h1,
    OP_TRUNC64  = 4'h2,
    OP_LOAD     = 4'h3,
    OP_ODD_DUP  = 4'h4,
    OP_EVEN_DUP = 4'h5,
    OP_QUAD_DUP = 4'h6,
    OP_WATCH    = 4'h7,
    OP_WAIT     = 4'h8,
    OP_NONE     = 4'hF
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MEM  = 2'b10
  } state_t;

endpackage

// File: hdl/conv_if.sv
`timescale 1ns/1ps
interface conv_if;
  import simd_dup_pkg::*;
  logic [FPX_W-1:0] value;
  logic [1:0]       width;
  logic [QW_W-1:0]  result;
  logic             invalid;
  logic             inexact;
  modport conv (input value, width, output result, invalid, inexact);
  modport user (output value, width, input result, invalid, inexact);
endinterface

// File: hdl/fp_trunc_conv.sv
`timescale 1ns/1ps
module fp_trunc_conv
  import simd_dup_pkg::*;
(
  conv_if.conv c  // Operand in, truncated integer and flags out
);

  logic            sign;
  logic [14:0]     ex;
  logic [63:0]     mant;
  logic [15:0]     sh;
  logic [63:0]     mag;
  logic [63:0]     lost;
  logic [63:0]     lim;
  logic [63:0]     sres;
  logic            inv;

  function automatic logic [6:0] int_bits(input logic [1:0] w);
    case (w)
      IW_16:   int_bits = 7'd16;
      IW_32:   int_bits = 7'd32;
      default: int_bits = 7'd64;
    endcase
  endfunction

  // ****************************************************************
  // Conversion toward zero
  // ****************************************************************
  // Fraction bits below the binary point are dropped outright, so the
  // rounding field of any control word has no path into this logic.
  always_comb begin
    sign = c.value[79];
    ex   = c.value[78:64];
    mant = c.value[63:0];
    sh   = '0;
    mag  = '0;
    lost = '0;
    inv  = 1'b0;
    lim  = 64'h0000_0000_0000_0001 << (int_bits(c.width) - 7'd1);
    if (ex == EXP_SPECIAL) begin
      inv = 1'b1;
    end else if ({1'b0, ex} < EXP_BIAS) begin
      lost = mant;
    end else begin
      sh = {1'b0, ex} - EXP_BIAS;
      if (sh > 16'h003F) begin
        inv = 1'b1;
      end else begin
        mag  = mant >> (6'd63 - sh[5:0]);
        lost = mant << ({1'b0, sh[5:0]} + 7'd1);
      end
    end
    if (!inv && (sign ? (mag > lim) : (mag >= lim))) begin
      inv = 1'b1;
    end
    sres      = sign ? (~mag + 64'h0000_0000_0000_0001) : mag;
    c.invalid = inv;
    c.inexact = !inv && (lost != '0);
    c.result  = (inv ? lim : sres) & ((lim << 1) - 64'h0000_0000_0000_0001);
  end

endmodule

// File: verif/mem_responder.sv
`timescale 1ns/1ps
module mem_responder
  import simd_dup_pkg::*;
(
  input  wire logic              CLK,       // Core clock
  input  wire logic              RST_N,     // Asynchronous reset
  input  wire logic [7:0]        LATENCY,   // Wait before answer
  input  wire logic              MEM_REQ,   // Read request
  input  wire logic [ADDR_W-1:0] MEM_ADDR,  // Aligned address
  input  wire logic              MEM_WIDE,  // 32-byte fetch
  output logic                   MEM_VALID, // Answer present
  output logic [BLK_W-1:0]       MEM_DATA   // Answer block
);
  logic [7:0]        wait_r;
  logic              busy_r;
  logic [ADDR_W-1:0] addr_r;
  logic              wide_r;

  // Each byte within the fetched width is a function of its own address, so a wrong offset shows.
  function automatic logic [BLK_W-1:0] block(input logic [ADDR_W-1:0] a,
                                             input logic w);
    logic [BLK_W-1:0]  b;
    logic [ADDR_W-1:0] s;
    for (int i = 0; i < 32; i++) begin
      s = a + ADDR_W'(i);
      b[8*i +: 8] = (w || i < 16) ? (s[7:0] ^ 8'h5A) : (8'hE7 ^ 8'(i));
    end
    return b;
  endfunction

  // The data bus toggles whenever no answer stands, never showing stale data.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_r    <= 1'b0;
      wait_r    <= 8'h00;
      addr_r    <= '0;
      wide_r    <= 1'b0;
      MEM_VALID <= 1'b0;
      MEM_DATA  <= '0;
    end else begin
      MEM_VALID <= 1'b0;
      MEM_DATA  <= ~MEM_DATA;
      if (MEM_REQ && !busy_r) begin
        busy_r <= 1'b1;
        wait_r <= LATENCY;
        addr_r <= MEM_ADDR;
        wide_r <= MEM_WIDE;
      end else if (busy_r && wait_r == 8'h00) begin
        busy_r    <= 1'b0;
        MEM_VALID <= 1'b1;
        MEM_DATA  <= block(addr_r, wide_r);
      end else if (busy_r) begin
        wait_r <= wait_r - 8'h01;
      end
    end
  end
endmodule

// File: verif/simd_dup_truncate_datapath_tb.sv
`timescale 1ns/1ps
module simd_dup_truncate_datapath_tb;
  import simd_dup_pkg::*;
  logic clk, rst_n, feat, lm, iv, pp, pr, pw;
  op_t iop;
  logic [2:0] di;
  logic [7:0] lat;
  logic [VEC_W-1:0] src, c_vd;
  logic [FPX_W-1:0] fp;
  logic [15:0] cw;
  logic [ADDR_W-1:0] ga, la, c_id, c_ma, c_wa;
  logic [31:0] gh, c_wh;
  logic [3:0] c_vi;
  logic [1:0] c_iw;
  logic c_mw;
  wire logic mv, rdy, ud, vwe, iwe, pop, inv, inx, flt, mrq, mw, wv, tv;
  wire logic [BLK_W-1:0] md;
  wire logic [31:0] idf, th;
  wire logic [3:0] vi;
  wire logic [VEC_W-1:0] vd;
  wire logic [63:0] idt, ma, wa;
  wire logic [1:0] iw;
  int errors = 0;
  int comparisons = 0;
  // Pulse counts: 0 vec, 1 int, 2 pop, 3 inv, 4 inx, 5 flt, 6 ud, 7 req,
  // 8 watch, 9 wait.
  int n[10];
  localparam logic [127:0] SRC = 128'hD3D3_0003_C2C2_0002_B1B1_0001_A0A0_0000;
  localparam logic [127:0] ODD = 128'hD3D3_0003_D3D3_0003_B1B1_0001_B1B1_0001;
  localparam logic [127:0] EVN = 128'hC2C2_0002_C2C2_0002_A0A0_0000_A0A0_0000;

  simd_dup_truncate_datapath i_simd_dup_truncate_datapath (
    .CLK(clk), .RST_N(rst_n), .FEATURE_EN(feat), .LONG_MODE(lm),
    .ISSUE_VALID(iv), .ISSUE_OP(iop), .DEST_IDX(di), .PFX_PRESENT(pp),
    .PFX_R(pr), .PFX_W(pw), .VEC_SRC(src), .FP_TOP(fp), .FP_CW(cw),
    .GPR_ADDR(ga), .GPR_HINT(gh), .LOAD_ADDR(la), .MEM_VALID(mv),
    .MEM_DATA(md), .ISSUE_READY(rdy), .ID_FLAGS(idf), .UD_FAULT(ud),
    .VEC_WE(vwe), .VEC_IDX(vi), .VEC_DATA(vd), .INT_WE(iwe),
    .INT_DATA(idt), .INT_WIDTH(iw), .FP_POP(pop), .FP_INVALID(inv),
    .FP_INEXACT(inx), .FP_FAULT(flt), .MEM_REQ(mrq), .MEM_ADDR(ma),
    .MEM_WIDE(mw), .WATCH_VALID(wv), .WATCH_ADDR(wa), .WAIT_VALID(tv),
    .WAIT_HINT(th));

  mem_responder i_mem_responder (
    .CLK(clk), .RST_N(rst_n), .LATENCY(lat), .MEM_REQ(mrq), .MEM_ADDR(ma),
    .MEM_WIDE(mw), .MEM_VALID(mv), .MEM_DATA(md));

  always #50 clk = ~clk;

  // Outputs are sampled on the edge that ends their cycle.
  always @(posedge clk) begin
    if (vwe === 1'b1) begin n[0]++; c_vd = vd; c_vi = vi; end
    if (iwe === 1'b1) begin n[1]++; c_id = idt; c_iw = iw; end
    if (pop === 1'b1) n[2]++;
    if (inv === 1'b1) n[3]++;
    if (inx === 1'b1) n[4]++;
    if (flt === 1'b1) n[5]++;
    if (ud === 1'b1) n[6]++;
    if (mrq === 1'b1) begin n[7]++; c_ma = ma; c_mw = mw; end
    if (wv === 1'b1) begin n[8]++; c_wa = wa; end
    if (tv === 1'b1) begin n[9]++; c_wh = th; end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic issue(input op_t op);
    int k;
    k = 0;
    while (rdy !== 1'b1) begin
      if (k == 20) begin
        errors++;
        $display("[FAIL] %0t ready never came", $time);
        conclude();
      end
      @(posedge clk); #1; k++;
    end
    foreach (n[i]) n[i] = 0;
    @(posedge clk);
    iv <= 1'b1; iop <= op;
    @(posedge clk);
    iv <= 1'b0; iop <= OP_NONE;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_dup();
    logic [3:0] cfg[4] = '{4'b1110, 4'b0110, 4'b1010, 4'b1101};
    @(posedge clk); src <= SRC; di <= 3'h5;
    issue(OP_EVEN_DUP); settle();
    chk(c_vd, EVN, "even");
    issue(OP_QUAD_DUP); settle();
    chk(c_vd, {SRC[63:0], SRC[63:0]}, "quad");
    chk(n[0], 1, "single write");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk); {lm, pp, pr, pw} <= cfg[i];
      issue(OP_ODD_DUP); settle();
      chk(c_vd, ODD, "odd");
      chk(c_vi, (i == 0) ? 4'hD : 4'h5, "index");
    end
    $display("test dup done");
  endtask

  task automatic tr(input op_t op, input logic [79:0] v, input logic [15:0] c,
                    input logic [63:0] e, input logic [4:0] f);
    logic [1:0] w;
    w = (op == OP_TRUNC16) ? IW_16 : (op == OP_TRUNC32) ? IW_32 : IW_64;
    @(posedge clk); fp <= v; cw <= c;
    issue(op); settle();
    chk(n[1], f[4], "store");
    chk(n[2], f[3], "pop");
    chk({n[3], n[4], n[5]}, {32'(f[2]), 32'(f[1]), 32'(f[0])}, "flags");
    if (f[4]) begin
      chk(c_id, e, "int data");
      chk(c_iw, w, "int width");
    end
  endtask

  task automatic ld(input logic [63:0] a, input logic [7:0] l,
                    input logic [3:0] ei);
    logic [127:0] e;
    logic [63:0] s;
    int k;
    for (int j = 0; j < 16; j++) begin
      s = a + 64'(j);
      e[8*j +: 8] = s[7:0] ^ 8'h5A;
    end
    @(posedge clk); la <= a; lat <= l;
    issue(OP_LOAD); #1;
    chk(rdy, 1'b0, "busy in load");
    k = 0;
    while (n[0] == 0) begin
      if (k == 20) begin
        errors++;
        $display("[FAIL] %0t load never ended", $time);
        conclude();
      end
      @(posedge clk); #1; k++;
    end
    chk(c_ma, {a[63:4], 4'h0}, "fetch addr");
    chk(c_mw, a[3:0] != 4'h0, "fetch wide");
    chk(c_vd, e, "load data");
    chk(c_vi, ei, "load index");
    chk(n[7], 1, "one request");
    $display("test load done");
  endtask

  task automatic wt(input logic [3:0] c, input logic [63:0] e);
    @(posedge clk); {lm, pp, pr, pw} <= c;
    issue(OP_WATCH); settle();
    chk(c_wa, e, "watch addr");
    chk(n[8], 1, "one watch");
    issue(OP_WAIT); settle();
    chk(c_wh, gh, "wait hint");
    chk(n[9], 1, "one wait");
  endtask

  task automatic t_absent();
    @(posedge clk); feat <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(idf, 32'h0000_0000, "flag clear");
    issue(OP_ODD_DUP); settle();
    chk({n[6], n[0]}, {32'd1, 32'd0}, "absent dup");
    issue(OP_TRUNC32); settle();
    chk({n[6], n[1], n[2]}, {32'd1, 32'd0, 32'd0}, "absent store");
    @(posedge clk); feat <= 1'b1;
    issue(OP_NONE); settle();
    chk(n[0] + n[1] + n[6], 0, "no-op");
    $display("test absent done");
  endtask

  initial begin
    clk = 1'b0; rst_n = 1'b0; feat = 1'b1; lm = 1'b0; iv = 1'b0;
    iop = OP_NONE; di = 3'h0; pp = 1'b0; pr = 1'b0; pw = 1'b0;
    src = '0; fp = '0; cw = 16'h037F; la = '0; lat = 8'h00;
    ga = 64'h1234_5678_9ABC_DEF0; gh = 32'h0000_00F1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(idf, 32'h0000_0001, "flag set");
    t_dup();
    tr(OP_TRUNC16, 80'hC000_B000_0000_0000_0000, 16'h037F,
       64'h0000_0000_0000_FFFE, 5'b11010);
    tr(OP_TRUNC32, 80'h4000_B000_0000_0000_0000, 16'h087F,
       64'h0000_0000_0000_0002, 5'b11010);
    tr(OP_TRUNC64, 80'hC000_B000_0000_0000_0000, 16'h077F,
       64'hFFFF_FFFF_FFFF_FFFE, 5'b11010);
    tr(OP_TRUNC32, 80'h4005_C800_0000_0000_0000, 16'h035F,
       64'h0000_0000_0000_0064, 5'b11000);
    tr(OP_TRUNC16, 80'h4000_B000_0000_0000_0000, 16'h035F,
       64'h0000_0000_0000_0002, 5'b11011);
    tr(OP_TRUNC32, 80'h7FFF_C000_0000_0000_0000, 16'h037F,
       64'h0000_0000_8000_0000, 5'b11100);
    tr(OP_TRUNC64, 80'h7FFF_C000_0000_0000_0000, 16'h037E,
       64'h0, 5'b00101);
    $display("test store done");
    @(posedge clk); {lm, pp, pr, pw} <= 4'b0000;
    ld(64'h0000_1000_0000_2340, 8'd3, 4'h5);
    ld(64'h0000_1000_0000_2345, 8'd0, 4'h5);
    @(posedge clk); {lm, pp, pr} <= 3'b111;
    ld(64'h0000_1000_0000_234F, 8'd5, 4'hD);
    wt(4'b1101, ga);
    wt(4'b1100, {32'h0, ga[31:0]});
    wt(4'b0101, {32'h0, ga[31:0]});
    $display("test watch done");
    t_absent();
    conclude();
  end
endmodule
